// file: common/ach_defines.svh
`ifndef ACH_DEFINES_SVH
`define ACH_DEFINES_SVH
// clock rate, strobe timing and card reset length
`define ACH_CLK_HZ          40000000
`define ACH_CLK_NS          25
`define ACH_SETUP_NS        70
`define ACH_SETUP_CYC       ((`ACH_SETUP_NS + `ACH_CLK_NS - 1) / `ACH_CLK_NS)
`define ACH_STROBE_NS       165
`define ACH_STROBE_CYC      ((`ACH_STROBE_NS + `ACH_CLK_NS - 1) / `ACH_CLK_NS)
`define ACH_HOLD_NS         30
`define ACH_HOLD_CYC        ((`ACH_HOLD_NS + `ACH_CLK_NS - 1) / `ACH_CLK_NS)
`define ACH_RESET_NS        25000
`define ACH_RESET_CYC       ((`ACH_RESET_NS + `ACH_CLK_NS - 1) / `ACH_CLK_NS)
// taskfile byte lane of the data word
`define ACH_TASK_MASK       16'h00FF
`endif

// file: common/ach_pkg.sv
package ach_pkg;
    // one access request from the controller side
    typedef struct packed {
        logic        write;
        logic        alt_sel;
        logic        wide;
        logic [2:0]  addr;
        logic [15:0] data;
    } ach_req_s;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_SETUP  = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_HOLD   = 5'b01000,
        ST_RESET  = 5'b10000
    } ach_state_e;
endpackage

// file: design/ach_port.sv
// Overview of operation
// - alternate select driven low asserts, high negates
// - taskfile select low during taskfile accesses
// - three-bit register address presented to card
// - high interrupt input means pending request
// - taskfile uses low byte, data full width
// - ready input is active high
// - each card-detect input asserted when low
// - hardware reset low resets, high normally
// - read strobe pulsed low with select, address
// - write strobe pulsed low with data valid
// - only direct ATA mode supported
`timescale 1ns/1ps
`default_nettype none
`include "ach_defines.svh"
module ach_port
    import ach_pkg::*;
#(
    parameter int RESET_CYC = `ACH_RESET_CYC
)(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CARD_RESET_REQ,
    input  wire ach_req_s    REQ,
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    output logic [15:0]      RSP_DATA,
    output logic             RSP_VALID,
    input  wire logic        RSP_READY,
    output logic             CARD_PRESENT,
    output logic             CARD_INT_PENDING,
    output logic             CARD_SELECT_ALT_N,
    output logic             CARD_SELECT_TASKFILE_N,
    output logic [2:0]       CARD_REG_ADDR,
    output logic             CARD_READ_STROBE_N,
    output logic             CARD_WRITE_STROBE_N,
    output logic             CARD_HW_RESET_N,
    output logic [15:0]      CARD_DATA_O,
    output logic             CARD_DATA_OE,
    input  wire logic [15:0] CARD_DATA_I,
    input  wire logic        CARD_INT_REQUEST,
    input  wire logic        CARD_IO_READY,
    input  wire logic        CARD_DETECT_A_N,
    input  wire logic        CARD_DETECT_B_N
);
    localparam int CW = 16;

    // lane selection shared by write drive and read capture: taskfile accesses keep the low byte only
    function automatic logic [15:0] lane_word(input logic wide, input logic [15:0] word);
        return wide ? word : (word & `ACH_TASK_MASK);
    endfunction

    // two-flop synchronisers for all card inputs; stage one read only by stage two
    logic [3:0]  sync1_ff, sync2_ff;
    logic [15:0] dsync1_ff, dsync2_ff;
    always_ff @(posedge CLK)
    begin
        sync1_ff  <= {CARD_INT_REQUEST, CARD_IO_READY, CARD_DETECT_A_N, CARD_DETECT_B_N};
        sync2_ff  <= sync1_ff;
        dsync1_ff <= CARD_DATA_I;
        dsync2_ff <= dsync1_ff;
    end

    wire int_req  = sync2_ff[3];
    wire io_ready = sync2_ff[2];
    wire present  = ~sync2_ff[1] & ~sync2_ff[0];

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            CARD_PRESENT     <= 1'b0;
            CARD_INT_PENDING <= 1'b0;
        end
        else
        begin
            CARD_PRESENT     <= present;
            CARD_INT_PENDING <= int_req & present;
        end
    end

    // two-entry read-response buffer so a stalled receiver loses no word
    logic [15:0] buf_mem [2];
    logic        wp_ff, rp_ff;
    logic [1:0]  cnt_ff;
    logic        push;
    logic [15:0] nxt_rd_data;
    wire         buf_full = (cnt_ff == 2'h2);
    wire         pop      = RSP_VALID & RSP_READY;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end
        else
        begin
            if (push)
                wp_ff <= ~wp_ff;
            if (pop)
                rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge CLK)
    begin
        if (push)
            buf_mem[wp_ff] <= nxt_rd_data;
    end
    // outputs registered: next pointer view computed ahead
    wire [1:0] nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
    wire       nxt_rp  = pop ? ~rp_ff : rp_ff;
    always_ff @(posedge CLK)
    begin
        if (RST)
            RSP_VALID <= 1'b0;
        else
            RSP_VALID <= (nxt_cnt != 2'h0);
    end
    // data mux reads memory or the word being pushed into an empty buffer
    always_ff @(posedge CLK)
    begin
        if (RST)
            RSP_DATA <= 16'h0000;
        else if (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && pop))
            RSP_DATA <= (cnt_ff == 2'h1 && !push) ? buf_mem[nxt_rp] : nxt_rd_data;
        else
            RSP_DATA <= buf_mem[nxt_rp];
    end

    // access sequencer, direct ATA mode only: no memory or io-card cycles
    ach_state_e  st_ff, nxt_st;
    logic [CW-1:0] cyc_ff;
    ach_req_s    req_ff;
    wire         cyc_done = (cyc_ff == '0);
    wire         take     = REQ_READY & REQ_VALID;
    // a request, read or write, may only launch when the response buffer is empty
    wire         can_take = (st_ff == ST_IDLE) & ~CARD_RESET_REQ & (cnt_ff == 2'h0);

    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE:   nxt_st = take ? ST_SETUP : (CARD_RESET_REQ ? ST_RESET : ST_IDLE); // accepted request never lost
            ST_SETUP:  nxt_st = cyc_done ? ST_STROBE : ST_SETUP;
            ST_STROBE: nxt_st = (cyc_done & io_ready) ? ST_HOLD : ST_STROBE;
            ST_HOLD:   nxt_st = cyc_done ? ST_IDLE : ST_HOLD;
            ST_RESET:  nxt_st = cyc_done ? ST_IDLE : ST_RESET;
            default:   nxt_st = ST_IDLE;
        endcase
    end

    // low byte only for taskfile accesses
    assign nxt_rd_data  = lane_word(req_ff.wide, dsync2_ff);
    assign push         = (st_ff == ST_STROBE) & (nxt_st == ST_HOLD) & ~req_ff.write;
    wire   in_cycle     = (nxt_st == ST_SETUP) | (nxt_st == ST_STROBE) | (nxt_st == ST_HOLD);
    wire   nxt_strobe   = (nxt_st == ST_STROBE);

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_ff  <= ST_IDLE;
            cyc_ff <= '0;
            req_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
            if (take)
                req_ff <= REQ;
            if (nxt_st != st_ff)
                case (nxt_st)
                    ST_SETUP:  cyc_ff <= CW'(`ACH_SETUP_CYC - 1);
                    ST_STROBE: cyc_ff <= CW'(`ACH_STROBE_CYC - 1);
                    ST_HOLD:   cyc_ff <= CW'(`ACH_HOLD_CYC - 1);
                    ST_RESET:  cyc_ff <= CW'(RESET_CYC - 1);
                    default:   cyc_ff <= '0;
                endcase
            else if (!cyc_done)
                cyc_ff <= cyc_ff - 1'b1;
        end
    end

    // registered pin drive; select and address span setup through hold
    ach_req_s nreq;
    assign nreq = take ? REQ : req_ff;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            REQ_READY              <= 1'b0;
            CARD_SELECT_ALT_N      <= 1'b1;
            CARD_SELECT_TASKFILE_N <= 1'b1;
            CARD_REG_ADDR          <= 3'h0;
            CARD_READ_STROBE_N     <= 1'b1;
            CARD_WRITE_STROBE_N    <= 1'b1;
            CARD_HW_RESET_N        <= 1'b1;
            CARD_DATA_O            <= 16'h0000;
            CARD_DATA_OE           <= 1'b0;
        end
        else
        begin
            REQ_READY              <= can_take & ~take & (nxt_st == ST_IDLE);
            CARD_SELECT_ALT_N      <= ~(in_cycle & nreq.alt_sel);
            CARD_SELECT_TASKFILE_N <= ~(in_cycle & ~nreq.alt_sel);
            CARD_REG_ADDR          <= in_cycle ? nreq.addr : 3'h0;
            CARD_READ_STROBE_N     <= ~(nxt_strobe & ~nreq.write);
            CARD_WRITE_STROBE_N    <= ~(nxt_strobe & nreq.write);
            CARD_HW_RESET_N        <= (nxt_st != ST_RESET);
            CARD_DATA_O            <= lane_word(nreq.wide, nreq.data);
            CARD_DATA_OE           <= in_cycle & nreq.write;
        end
    end

    // checks
    chk_strobe_select: assert property (@(posedge CLK) disable iff (RST)
        (!CARD_READ_STROBE_N || !CARD_WRITE_STROBE_N) |-> (CARD_SELECT_ALT_N != CARD_SELECT_TASKFILE_N))
        else $error("strobe without exactly one select");
    chk_write_data: assert property (@(posedge CLK) disable iff (RST)
        !CARD_WRITE_STROBE_N |-> CARD_DATA_OE)
        else $error("write strobe without data drive");
    chk_read_nodrive: assert property (@(posedge CLK) disable iff (RST)
        !CARD_READ_STROBE_N |-> !CARD_DATA_OE)
        else $error("data driven during read");
    chk_ready_stretch: assert property (@(posedge CLK) disable iff (RST)
        (st_ff == ST_STROBE && !io_ready) |=> (st_ff == ST_STROBE))
        else $error("strobe ended while card not ready");
    chk_present_both: assert property (@(posedge CLK) disable iff (RST)
        CARD_PRESENT |-> $past(~sync2_ff[1] & ~sync2_ff[0]))
        else $error("present without both detects");
    chk_int_level: assert property (@(posedge CLK) disable iff (RST)
        CARD_INT_PENDING |-> $past(int_req))
        else $error("interrupt pending without request");
    chk_reset_hold: assert property (@(posedge CLK) disable iff (RST)
        $fell(CARD_HW_RESET_N) |-> !CARD_HW_RESET_N [*2])
        else $error("card reset pulse too short");
    chk_task_byte: assert property (@(posedge CLK) disable iff (RST)
        (CARD_DATA_OE && !req_ff.wide && st_ff != ST_IDLE) |-> (CARD_DATA_O[15:8] == 8'h00))
        else $error("taskfile write drove high byte");
    cov_read:  cover property (@(posedge CLK) disable iff (RST) push);
    cov_write: cover property (@(posedge CLK) disable iff (RST) $rose(CARD_WRITE_STROBE_N));
    cov_wait:  cover property (@(posedge CLK) disable iff (RST) st_ff == ST_STROBE && !io_ready);
    cov_full:  cover property (@(posedge CLK) disable iff (RST) buf_full);
endmodule
`default_nettype wire

// file: tb/ach_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// card stand-in: eight words behind the register address, optional slow ready
module ach_card_model (
    input  wire logic        clk,
    input  wire logic        cs_n,
    input  wire logic [2:0]  addr,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] dout,
    input  wire logic        slow,
    output logic [15:0]      din,
    output logic             io_ready
);
    logic [15:0] mem [8] = '{default: 16'h0000};
    logic [3:0]  hold    = 4'h0;
    logic        idle_q  = 1'b1;
    // pull-downs on the data lines: a released bus reads zero, never the last word
    assign din = (!rd_n && !cs_n) ? mem[addr] : 16'h0000;
    assign io_ready = (hold == 4'h0);
    // a slow card holds ready low for twelve cycles from each strobe fall
    always @(posedge clk)
    begin
        idle_q <= rd_n & wr_n;
        if (hold != 4'h0) hold <= hold - 4'h1;
        else if (slow && idle_q && !(rd_n & wr_n)) hold <= 4'hC;
        if (!wr_n && !cs_n) mem[addr] <= dout;
    end
endmodule
`default_nettype wire

// file: tb/tb_ata_card_host_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "ach_defines.svh"
module tb_ata_card_host_port;
    import ach_pkg::*;
    logic CLK = 0, RST = 1, CARD_RESET_REQ = 0, REQ_VALID = 0, RSP_READY = 1, REQ_READY, RSP_VALID;
    logic CARD_INT_REQUEST = 0, CARD_DETECT_A_N = 0, CARD_DETECT_B_N = 0, slow = 0, rdy, CARD_PRESENT;
    logic CARD_INT_PENDING, CARD_SELECT_ALT_N, CARD_SELECT_TASKFILE_N, rd_n, wr_n, rst_n, oe;
    logic [2:0]  addr;
    logic [15:0] RSP_DATA, dout, din, q;
    logic [21:0] seen;
    ach_req_s    REQ = '0;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, wid = 0;
    realtime t0;
    always #12.5 CLK = ~CLK;
    ach_port #(.RESET_CYC(8)) dut (.CLK(CLK), .RST(RST), .CARD_RESET_REQ(CARD_RESET_REQ), .REQ(REQ),
        .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RSP_DATA(RSP_DATA), .RSP_VALID(RSP_VALID),
        .RSP_READY(RSP_READY), .CARD_PRESENT(CARD_PRESENT), .CARD_INT_PENDING(CARD_INT_PENDING),
        .CARD_SELECT_ALT_N(CARD_SELECT_ALT_N), .CARD_SELECT_TASKFILE_N(CARD_SELECT_TASKFILE_N),
        .CARD_REG_ADDR(addr), .CARD_READ_STROBE_N(rd_n), .CARD_WRITE_STROBE_N(wr_n), .CARD_HW_RESET_N(rst_n),
        .CARD_DATA_O(dout), .CARD_DATA_OE(oe), .CARD_DATA_I(din), .CARD_INT_REQUEST(CARD_INT_REQUEST),
        .CARD_IO_READY(rdy), .CARD_DETECT_A_N(CARD_DETECT_A_N), .CARD_DETECT_B_N(CARD_DETECT_B_N));
    ach_card_model card (.clk(CLK), .cs_n(CARD_SELECT_ALT_N & CARD_SELECT_TASKFILE_N), .addr(addr),
        .rd_n(rd_n), .wr_n(wr_n), .dout(oe ? dout : 16'h0000), .slow(slow), .din(din), .io_ready(rdy));
    // pin snapshot at each strobe fall, and read strobe width in cycles
    always @(negedge rd_n or negedge wr_n)
    begin
        seen = {CARD_SELECT_ALT_N, CARD_SELECT_TASKFILE_N, addr, dout, oe};
        t0 = $realtime;
    end
    always @(posedge rd_n) wid = int'(($realtime - t0) / 25.0);
    // hang guard: far beyond the few hundred cycles the scenarios need
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one request; reads return when the response shows, writes when idle again
    task automatic access(input logic w, alt, wide, input logic [2:0] a, input logic [15:0] d);
        int n;
        @(posedge CLK);
        REQ <= '{write: w, alt_sel: alt, wide: wide, addr: a, data: d};
        REQ_VALID <= 1'b1;
        @(negedge CLK);
        for (n = 0; n < 500 && REQ_READY !== 1'b1; n++) @(negedge CLK);
        if (n == 500)
        begin
            n_mismatch++;
            $display("[FAIL] %0t request never accepted", $time);
        end
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        repeat (2) @(negedge CLK);
        for (n = 0; n < 500 && (w ? REQ_READY : RSP_VALID) !== 1'b1; n++) @(negedge CLK);
        if (n == 500)
        begin
            n_mismatch++;
            $display("[FAIL] %0t access never completed", $time);
        end
        q = RSP_DATA;
    endtask
    task automatic t_wide();
        access(1, 0, 1, 3'h5, 16'hA5C3);
        chk(seen, {2'b10, 3'h5, 16'hA5C3, 1'b1});
        access(0, 0, 1, 3'h5, 16'h0000);
        chk(q, 16'hA5C3);
        chk(seen[0], 1'b0);
        chk(wid, `ACH_STROBE_CYC);
        access(0, 0, 0, 3'h5, 16'h0000);
        chk(q, 16'h00C3);
    endtask
    task automatic t_taskfile();
        for (int a = 0; a < 8; a++)
        begin
            access(1, 0, 0, a[2:0], 16'hFF30 + 16'(a));
            access(0, 0, 0, a[2:0], 16'h0000);
            chk(q, 16'h0030 + 16'(a));
        end
    endtask
    task automatic t_alt();
        access(1, 1, 0, 3'h6, 16'h0011);
        chk(seen[21:17], {2'b01, 3'h6});
    endtask
    task automatic t_slow_and_stall();
        @(posedge CLK);
        slow <= 1'b1;
        RSP_READY <= 1'b0;
        access(0, 0, 1, 3'h5, 16'h0000);
        chk(wid > 12, 1'b1);
        chk(q, 16'h0035);
        repeat (6) @(negedge CLK);
        chk({RSP_VALID, REQ_READY, RSP_DATA}, {2'b10, 16'h0035});
        @(posedge CLK);
        RSP_READY <= 1'b1;
        slow <= 1'b0;
        repeat (2) @(negedge CLK);
        chk(RSP_VALID, 1'b0);
    endtask
    task automatic t_detect_irq();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge CLK);
            {CARD_DETECT_A_N, CARD_DETECT_B_N, CARD_INT_REQUEST} <= {i[1:0], 1'b1};
            repeat (6) @(negedge CLK);
            chk({CARD_PRESENT, CARD_INT_PENDING}, {2{i == 0}});
        end
        @(posedge CLK);
        {CARD_DETECT_A_N, CARD_DETECT_B_N, CARD_INT_REQUEST} <= 3'b000;
        repeat (6) @(negedge CLK);
        chk({CARD_PRESENT, CARD_INT_PENDING}, 2'b10);
    endtask
    task automatic t_hw_reset();
        @(posedge CLK);
        CARD_RESET_REQ <= 1'b1;
        @(posedge CLK);
        CARD_RESET_REQ <= 1'b0;
        repeat (3) @(negedge CLK);
        chk(rst_n, 1'b0);
        repeat (30) @(negedge CLK);
        chk({rst_n, REQ_READY}, 2'b11);
    endtask
    initial
    begin
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        repeat (3) @(negedge CLK);
        chk({CARD_SELECT_ALT_N, CARD_SELECT_TASKFILE_N, rd_n, wr_n, rst_n, oe}, 6'b111110);
        t_wide();
        t_taskfile();
        t_alt();
        t_slow_and_stall();
        t_detect_irq();
        t_hw_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
